// ### design/tpg_control.v
// Control block for receive power modes and transmit power, rate, gain and offset.
// Assumes all inputs synchronous to clk_i; settings arrive as a write strobe with
// an index and data, plus separate per-field write strobes for transmit settings.
//
// Contract
// - Half-bias pin halves receive bias currents.
// - Ultralow power needs pin plus three writes.
// - Each receive channel enters standby independently.
// - Both channels off switches receive references off.
// - Two cascaded interpolation stages: 1x, 2x, 4x.
// - Powerdown pin gates transmit clocks, keeps biases.
// - Sleep turns off only output currents.
// - Configuration port works during transmit powerdown.
// - Per-converter coarse gain: 1, 1/2, 1/11.
// - Shared 8-bit gain, 0 to -20 dB.
// - Per-channel 6-bit fine gain, four percent.
// - Reset: coarse 1x, shared 0 dB, fine 0.
// - Offset steering picks exactly one output.
// - Fast update doubles shared gain settling speed.
// - Multiplier enabled derives clocks from reference.
`timescale 1ns/10ps
`include "tpg_consts.vh"

module tpg_control #(
  parameter GAIN_W   = 8,
  parameter FINE_W   = 6,
  parameter OFFS_W   = 10
) (
  input  wire              clk_i,
  input  wire              rst_i,
  // Receive side controls
  input  wire              rx_half_bias_pin_i,
  input  wire              cfg_we_i,
  input  wire [3:0]        cfg_addr_i,
  input  wire [7:0]        cfg_wdata_i,
  output reg  [7:0]        cfg_rdata_o,
  // Transmit side controls
  input  wire              tx_powerdown_pin_i,
  input  wire              tx_sleep_we_i,
  input  wire              tx_sleep_i,
  input  wire              interp_we_i,
  input  wire [1:0]        interp_rate_i,
  input  wire              coarse_we_i,
  input  wire [1:0]        coarse_a_i,
  input  wire [1:0]        coarse_b_i,
  input  wire              shared_gain_we_i,
  input  wire [GAIN_W-1:0] shared_gain_i,
  input  wire              fast_update_we_i,
  input  wire              fast_update_i,
  input  wire              fine_we_i,
  input  wire [FINE_W-1:0] fine_a_i,
  input  wire [FINE_W-1:0] fine_b_i,
  input  wire              offset_we_i,
  input  wire [OFFS_W-1:0] offset_a_i,
  input  wire              offset_a_neg_i,
  input  wire [OFFS_W-1:0] offset_b_i,
  input  wire              offset_b_neg_i,
  input  wire              mult_we_i,
  input  wire              mult_en_i,
  input  wire              tx_reference_clock_in_i,
  // Receive status and analog controls
  output reg               rx_bias_half_o,
  output reg               rx_ultralow_o,
  output reg  [1:0]        rx_a_state_o,
  output reg  [1:0]        rx_b_state_o,
  output reg               rx_ref_on_o,
  // Transmit analog and clock controls
  output reg               tx_clk_gate_o,
  output reg               tx_bias_on_o,
  output reg               tx_out_current_on_o,
  output reg               interp_stage1_en_o,
  output reg               interp_stage2_en_o,
  output reg  [1:0]        coarse_a_o,
  output reg  [1:0]        coarse_b_o,
  output reg  [GAIN_W-1:0] shared_gain_o,
  output reg               shared_gain_fast_o,
  output reg  [FINE_W-1:0] fine_a_o,
  output reg  [FINE_W-1:0] fine_b_o,
  output reg  [OFFS_W-1:0] positive_current_output_offs_a_o,
  output reg  [OFFS_W-1:0] negative_current_output_offs_a_o,
  output reg  [OFFS_W-1:0] positive_current_output_offs_b_o,
  output reg  [OFFS_W-1:0] negative_current_output_offs_b_o,
  output reg               sync_clk_src_mult_o,
  output reg               tx_ref_sample_o
);

  // Configuration shadow registers
  reg [7:0]        reg_rx_a;
  reg [7:0]        reg_rx_b;
  reg [7:0]        reg_rx_ref;
  reg [7:0]        reg_ulp8;
  reg [7:0]        reg_ulp9;
  reg [7:0]        reg_ulpa;
  reg              half_bias_at_pwrup;
  reg              pwrup_seen;
  reg              tx_sleep;
  reg [1:0]        interp_rate;
  reg [OFFS_W-1:0] offs_a;
  reg [OFFS_W-1:0] offs_b;
  reg              offs_a_neg;
  reg              offs_b_neg;
  reg              mult_en;

  wire [1:0] next_rx_a_state;
  wire [1:0] next_rx_b_state;

  wire       next_rx_ref_on;
  wire       ulp_regs_match;

  // Channel state decode from a control byte: bit 0 standby, bit 1 full off
  function [1:0] rx_state;
    input [7:0] r;
    begin
      if (r[1])
        rx_state = `TPG_RX_OFF;
      else if (r[0])
        rx_state = `TPG_RX_STANDBY;
      else
        rx_state = `TPG_RX_ON;
    end
  endfunction

  // Offset lands on the selected output and zero on the other
  function [OFFS_W-1:0] steer;
    input [OFFS_W-1:0] val;
    input              sel;
    begin
      steer = sel ? val : {OFFS_W{1'b0}};
    end
  endfunction

  // Second stage only ever runs behind the first
  function stage_en;
    input [1:0] rate;
    input       second;
    begin
      case (rate)
        `TPG_INTERP_2X: stage_en = !second;
        `TPG_INTERP_4X: stage_en = 1'b1;
        default:        stage_en = 1'b0;
      endcase
    end
  endfunction

  // Register 5 bits act on both channels at once
  assign next_rx_a_state = rx_state(reg_rx_a | {6'h00, reg_rx_ref[1:0]});
  assign next_rx_b_state = rx_state(reg_rx_b | {6'h00, reg_rx_ref[1:0]});

  assign next_rx_ref_on  = !(next_rx_a_state == `TPG_RX_OFF
                             && next_rx_b_state == `TPG_RX_OFF);
  // Any other byte values leave the channels at plain half bias
  assign ulp_regs_match  = reg_ulp8 == `TPG_ULP_REG8_VAL
                           && reg_ulp9 == `TPG_ULP_REG9_VAL
                           && reg_ulpa == `TPG_ULP_REGA_VAL;

  // Port writes never depend on transmit powerdown, so settings stay reachable
  always @(posedge clk_i) begin
    if (rst_i) begin
      reg_rx_a   <= 8'h00;
      reg_rx_b   <= 8'h00;
      reg_rx_ref <= 8'h00;
      reg_ulp8   <= 8'h00;
      reg_ulp9   <= 8'h00;
      reg_ulpa   <= 8'h00;
    end else if (cfg_we_i) begin
      case (cfg_addr_i)
        `TPG_REG_RX_A:   reg_rx_a   <= cfg_wdata_i;
        `TPG_REG_RX_B:   reg_rx_b   <= cfg_wdata_i;
        `TPG_REG_RX_REF: reg_rx_ref <= cfg_wdata_i;
        `TPG_REG_ULP8:   reg_ulp8   <= cfg_wdata_i;
        `TPG_REG_ULP9:   reg_ulp9   <= cfg_wdata_i;
        `TPG_REG_ULPA:   reg_ulpa   <= cfg_wdata_i;
        // Writes to unmapped indices are dropped
        default:         reg_ulp8   <= reg_ulp8;
      endcase
    end
  end

  // Readback lags the address by one clock
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_rdata_o <= 8'h00;
    end else begin
      case (cfg_addr_i)
        `TPG_REG_RX_A:   cfg_rdata_o <= reg_rx_a;
        `TPG_REG_RX_B:   cfg_rdata_o <= reg_rx_b;
        `TPG_REG_RX_REF: cfg_rdata_o <= reg_rx_ref;
        `TPG_REG_ULP8:   cfg_rdata_o <= reg_ulp8;
        `TPG_REG_ULP9:   cfg_rdata_o <= reg_ulp9;
        `TPG_REG_ULPA:   cfg_rdata_o <= reg_ulpa;
        default:         cfg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Pin level is caught on the first clock after reset release
  // A later rise of the pin alone never enters ultralow
  always @(posedge clk_i) begin
    if (rst_i) begin
      pwrup_seen         <= 1'b0;
      half_bias_at_pwrup <= 1'b0;
    end else if (!pwrup_seen) begin
      pwrup_seen         <= 1'b1;
      half_bias_at_pwrup <= rx_half_bias_pin_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_bias_half_o <= 1'b0;
      rx_ultralow_o  <= 1'b0;
      rx_a_state_o   <= `TPG_RX_ON;
      rx_b_state_o   <= `TPG_RX_ON;
      rx_ref_on_o    <= 1'b1;
    end else begin
      rx_bias_half_o <= rx_half_bias_pin_i;
      rx_ultralow_o  <= half_bias_at_pwrup && rx_half_bias_pin_i
                        && ulp_regs_match;
      rx_a_state_o   <= next_rx_a_state;
      rx_b_state_o   <= next_rx_b_state;
      rx_ref_on_o    <= next_rx_ref_on;
    end
  end

  // Transmit settings: each held until rewritten or reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_sleep           <= 1'b0;
      interp_rate        <= `TPG_INTERP_1X;
      coarse_a_o         <= `TPG_COARSE_FULL;
      coarse_b_o         <= `TPG_COARSE_FULL;
      shared_gain_o      <= `TPG_SHARED_GAIN_RST;
      shared_gain_fast_o <= 1'b0;
      fine_a_o           <= `TPG_FINE_GAIN_RST;
      fine_b_o           <= `TPG_FINE_GAIN_RST;
      offs_a             <= `TPG_OFFSET_RST;
      offs_b             <= `TPG_OFFSET_RST;
      offs_a_neg         <= 1'b0;
      offs_b_neg         <= 1'b0;
      mult_en            <= 1'b0;
    end else begin
      if (tx_sleep_we_i)
        tx_sleep <= tx_sleep_i;
      // Code 3 has no rate; refusing it keeps the last valid one
      if (interp_we_i && interp_rate_i != 2'h3)
        interp_rate <= interp_rate_i;
      // Code 3 leaves that converter's coarse setting alone
      if (coarse_we_i) begin
        coarse_a_o <= (coarse_a_i == 2'h3) ? coarse_a_o : coarse_a_i;
        coarse_b_o <= (coarse_b_i == 2'h3) ? coarse_b_o : coarse_b_i;
      end
      if (shared_gain_we_i)
        shared_gain_o <= shared_gain_i;
      if (fast_update_we_i)
        shared_gain_fast_o <= fast_update_i;
      if (fine_we_i) begin
        fine_a_o <= fine_a_i;
        fine_b_o <= fine_b_i;
      end
      if (offset_we_i) begin
        offs_a     <= offset_a_i;
        offs_b     <= offset_b_i;
        offs_a_neg <= offset_a_neg_i;
        offs_b_neg <= offset_b_neg_i;
      end
      // Clock source is static; switch it only with the transmit path idle
      if (mult_we_i)
        mult_en <= mult_en_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_clk_gate_o       <= 1'b0;
      tx_bias_on_o        <= 1'b1;
      tx_out_current_on_o <= 1'b1;
      interp_stage1_en_o  <= 1'b0;
      interp_stage2_en_o  <= 1'b0;
      sync_clk_src_mult_o <= 1'b0;
      tx_ref_sample_o     <= 1'b0;
      positive_current_output_offs_a_o <= `TPG_OFFSET_RST;
      negative_current_output_offs_a_o <= `TPG_OFFSET_RST;
      positive_current_output_offs_b_o <= `TPG_OFFSET_RST;
      negative_current_output_offs_b_o <= `TPG_OFFSET_RST;
    end else begin
      // Biases stay up in powerdown so that recovery is quick
      tx_clk_gate_o       <= tx_powerdown_pin_i;
      tx_bias_on_o        <= 1'b1;
      tx_out_current_on_o <= !tx_sleep;
      interp_stage1_en_o  <= stage_en(interp_rate, 1'b0);
      interp_stage2_en_o  <= stage_en(interp_rate, 1'b1);
      sync_clk_src_mult_o <= mult_en;
      // Reference is only sampled here; the multiplier itself sits outside
      tx_ref_sample_o     <= tx_reference_clock_in_i;
      // One steering bit per channel, so the two outputs never both carry offset
      positive_current_output_offs_a_o <= steer(offs_a, !offs_a_neg);
      negative_current_output_offs_a_o <= steer(offs_a, offs_a_neg);
      positive_current_output_offs_b_o <= steer(offs_b, !offs_b_neg);
      negative_current_output_offs_b_o <= steer(offs_b, offs_b_neg);
    end
  end

endmodule // tpg_control

// ### design/tpg_consts.vh
// Constants for the converter power, rate and gain control block.
// Assumes inclusion by the design file and the property checks; definitions only.
`ifndef TPG_CONSTS_VH
`define TPG_CONSTS_VH

// Interpolation rate codes
`define TPG_INTERP_1X        2'h0
`define TPG_INTERP_2X        2'h1
`define TPG_INTERP_4X        2'h2

// Coarse gain codes
`define TPG_COARSE_FULL      2'h0
`define TPG_COARSE_HALF      2'h1
`define TPG_COARSE_ELEVENTH  2'h2

// Receive channel power states
`define TPG_RX_ON            2'h0
`define TPG_RX_STANDBY       2'h1
`define TPG_RX_OFF           2'h2

// Reset values
`define TPG_SHARED_GAIN_RST  8'hff
`define TPG_FINE_GAIN_RST    6'h00
`define TPG_OFFSET_RST       10'h000

// Ultralow power register values
`define TPG_ULP_REG8_VAL     8'h0c
`define TPG_ULP_REG9_VAL     8'h70
`define TPG_ULP_REGA_VAL     8'h70

// Configuration register indices
`define TPG_REG_RX_A         4'h3
`define TPG_REG_RX_B         4'h4
`define TPG_REG_RX_REF       4'h5
`define TPG_REG_ULP8         4'h8
`define TPG_REG_ULP9         4'h9
`define TPG_REG_ULPA         4'ha

`endif

// ### sim/tpg_props.sv
// Concurrent checks on the control block's ports.
// Assumes one clock, clk_i, and synchronous active-high reset rst_i.
`timescale 1ns/10ps
`include "tpg_consts.vh"
module tpg_props (
  input wire       clk_i,
  input wire       rst_i,
  input wire       rx_half_bias_pin_i,
  input wire       rx_bias_half_o,
  input wire       tx_powerdown_pin_i,
  input wire       tx_clk_gate_o,
  input wire       tx_bias_on_o,
  input wire [1:0] rx_a_state_o,
  input wire [1:0] rx_b_state_o,
  input wire       rx_ref_on_o,
  input wire [9:0] positive_current_output_offs_a_o,
  input wire [9:0] negative_current_output_offs_a_o,
  input wire       interp_stage1_en_o,
  input wire       interp_stage2_en_o,
  input wire       shared_gain_we_i,
  input wire [7:0] shared_gain_o,
  input wire       tx_sleep_we_i,
  input wire       tx_sleep_i,
  input wire       tx_out_current_on_o,
  input wire       rx_ultralow_o,
  input wire [1:0] coarse_a_o,
  input wire [1:0] coarse_b_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_sleep_req;
    tx_sleep_we_i && tx_sleep_i;
  endsequence
  sequence s_cur_off;
    ##2 !tx_out_current_on_o && tx_bias_on_o;
  endsequence
  property p_half_bias;
    !$past(rst_i) |-> rx_bias_half_o == $past(rx_half_bias_pin_i);
  endproperty
  property p_clk_gate;
    !$past(rst_i) |-> tx_clk_gate_o == $past(tx_powerdown_pin_i);
  endproperty
  property p_bias_on;
    tx_bias_on_o;
  endproperty
  property p_ref_off;
    rx_ref_on_o == !(rx_a_state_o == `TPG_RX_OFF && rx_b_state_o == `TPG_RX_OFF);
  endproperty
  property p_offs_one;
    !((|positive_current_output_offs_a_o) && (|negative_current_output_offs_a_o));
  endproperty
  property p_stage_order;
    interp_stage2_en_o |-> interp_stage1_en_o;
  endproperty
  // Gain must not drift between writes
  property p_gain_hold;
    !shared_gain_we_i |=> $stable(shared_gain_o);
  endproperty
  property p_sleep;
    s_sleep_req |-> s_cur_off;
  endproperty
  property p_coarse_legal;
    coarse_a_o != 2'h3 && coarse_b_o != 2'h3;
  endproperty
  property p_ultra_pin;
    rx_ultralow_o |-> rx_bias_half_o;
  endproperty
  a_half_bias:   assert property (p_half_bias) else $error("half bias not following pin");
  a_clk_gate:    assert property (p_clk_gate) else $error("clock gate not following pin");
  a_bias_on:     assert property (p_bias_on) else $error("transmit bias dropped");
  a_ref_off:     assert property (p_ref_off) else $error("receive reference state wrong");
  a_offs_one:    assert property (p_offs_one) else $error("offset on both outputs");
  a_stage_order: assert property (p_stage_order) else $error("stage two without one");
  a_gain_hold:   assert property (p_gain_hold) else $error("shared gain changed");
  a_sleep:       assert property (p_sleep) else $error("sleep left currents on");
  a_coarse_legal: assert property (p_coarse_legal) else $error("bad coarse code");
  a_ultra_pin:   assert property (p_ultra_pin) else $error("ultralow without half bias");
endmodule // tpg_props
bind tpg_control tpg_props u_props (.*);

// ### sim/tpg_host_model.sv
// Host side model: supplies the transmit reference clock.
// Assumes clk_i is the 125 MHz system clock.
`timescale 1ns/10ps
module tpg_host_model (
  input  wire  clk_i,
  output logic tx_reference_clock_in_i
);
  // Half system rate, inside every per-mode input limit
  initial tx_reference_clock_in_i = 1'b0;
  always @(negedge clk_i) tx_reference_clock_in_i <= ~tx_reference_clock_in_i;
endmodule // tpg_host_model

// ### sim/tb_top.sv
// Self-checking bench for the converter control block.
// Assumes inputs change on falling edges; outputs sampled there too.
`timescale 1ns/10ps
module tb_top;
  logic       clk_i = 1'b0, rst_i = 1'b1, rx_half_bias_pin_i = 1'b1, tx_powerdown_pin_i = 1'b0;
  logic [8:0] we = 9'h000;
  logic [7:0] cfg_wdata_i = 8'h00, shared_gain_i = 8'h00;
  logic [3:0] cfg_addr_i = 4'h0;
  logic [1:0] interp_rate_i = 2'h0, coarse_a_i = 2'h0, coarse_b_i = 2'h0;
  logic [5:0] fine_a_i = 6'h00, fine_b_i = 6'h00;
  logic [9:0] offset_a_i = 10'h000, offset_b_i = 10'h000;
  logic       tx_sleep_i = 1'b0, fast_update_i = 1'b0, mult_en_i = 1'b0;
  logic       offset_a_neg_i = 1'b0, offset_b_neg_i = 1'b0;
  wire        cfg_we_i = we[0], tx_sleep_we_i = we[1], interp_we_i = we[2], coarse_we_i = we[3];
  wire        shared_gain_we_i = we[4], fast_update_we_i = we[5], fine_we_i = we[6];
  wire        offset_we_i = we[7], mult_we_i = we[8], tx_reference_clock_in_i;
  wire [7:0]  cfg_rdata_o, shared_gain_o;
  wire [1:0]  rx_a_state_o, rx_b_state_o, coarse_a_o, coarse_b_o;
  wire [5:0]  fine_a_o, fine_b_o;
  wire [9:0]  positive_current_output_offs_a_o, negative_current_output_offs_a_o;
  wire [9:0]  positive_current_output_offs_b_o, negative_current_output_offs_b_o;
  wire        rx_bias_half_o, rx_ultralow_o, rx_ref_on_o, tx_clk_gate_o, tx_bias_on_o;
  wire        tx_out_current_on_o, interp_stage1_en_o, interp_stage2_en_o, shared_gain_fast_o;
  wire        sync_clk_src_mult_o, tx_ref_sample_o;
  int         num_errors = 0, tests_run = 0, cyc = 0;
  tpg_control uut (.*);
  tpg_host_model u_host (.*);
  initial forever #4 clk_i = ~clk_i;
  task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Pulse one strobe, then wait out the two-edge output latency
  task automatic strobe(input int b);
    @(negedge clk_i) we[b] = 1'b1;
    @(negedge clk_i) we = 9'h000;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic cfg_wr(input logic [3:0] a, input logic [7:0] d);
    cfg_addr_i = a;
    cfg_wdata_i = d;
    strobe(0);
  endtask
  task automatic cfg_rd(input logic [3:0] a, input logic [7:0] exp);
    cfg_addr_i = a;
    repeat (2) @(negedge clk_i);
    chk("cfg_rdata", cfg_rdata_o, exp);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    chk("coarse_a", coarse_a_o, 10'h000);
    chk("gain", shared_gain_o, 10'h0ff);
    chk("fine_b", fine_b_o, 10'h000);
    // Pin stayed high through reset, so these writes complete ultralow entry
    cfg_wr(4'h8, 8'h0c);
    cfg_wr(4'h9, 8'h70);
    cfg_wr(4'ha, 8'h70);
    chk("ultralow", rx_ultralow_o, 10'h001);
    chk("half_bias", rx_bias_half_o, 10'h001);
    rx_half_bias_pin_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("half_bias", rx_bias_half_o, 10'h000);
    chk("ultralow", rx_ultralow_o, 10'h000);
    cfg_wr(4'h3, 8'h01);
    chk("rx_a", rx_a_state_o, 10'h001);
    chk("rx_b", rx_b_state_o, 10'h000);
    cfg_wr(4'h4, 8'h02);
    chk("rx_b", rx_b_state_o, 10'h002);
    chk("ref", rx_ref_on_o, 10'h001);
    cfg_wr(4'h3, 8'h02);
    chk("ref", rx_ref_on_o, 10'h000);
    cfg_wr(4'hf, 8'h55);
    cfg_rd(4'hf, 8'h00);
    $display("receive tests done");
    tx_powerdown_pin_i = 1'b1;
    cfg_wr(4'h3, 8'h01);
    chk("clk_gate", tx_clk_gate_o, 10'h001);
    chk("bias", tx_bias_on_o, 10'h001);
    chk("rx_a", rx_a_state_o, 10'h001);
    chk("ref", rx_ref_on_o, 10'h001);
    cfg_rd(4'h3, 8'h01);
    tx_powerdown_pin_i = 1'b0;
    cfg_wr(4'h5, 8'h02);
    chk("clk_gate", tx_clk_gate_o, 10'h000);
    chk("rx_a", rx_a_state_o, 10'h002);
    chk("ref", rx_ref_on_o, 10'h000);
    cfg_rd(4'h5, 8'h02);
    for (int i = 0; i < 4; i++) begin
      interp_rate_i = 2'(i);
      strobe(2);
      chk("stage1", interp_stage1_en_o, 10'(i > 0));
      chk("stage2", interp_stage2_en_o, 10'(i > 1));
      coarse_a_i = 2'(i);
      coarse_b_i = 2'(i == 3 ? 3 : 2 - i);
      strobe(3);
      chk("coarse_a", coarse_a_o, 10'(i == 3 ? 2 : i));
      chk("coarse_b", coarse_b_o, 10'(i == 3 ? 0 : 2 - i));
    end
    shared_gain_i = 8'h80;
    fast_update_i = 1'b1;
    fine_a_i = 6'h3f;
    fine_b_i = 6'h01;
    strobe(4);
    strobe(5);
    strobe(6);
    shared_gain_i = 8'h11;
    repeat (5) @(negedge clk_i);
    chk("gain", shared_gain_o, 10'h080);
    chk("fast", shared_gain_fast_o, 10'h001);
    chk("fine_a", fine_a_o, 10'h03f);
    chk("fine_b", fine_b_o, 10'h001);
    offset_a_i = 10'h005;
    offset_a_neg_i = 1'b1;
    offset_b_i = 10'h3ff;
    strobe(7);
    chk("neg_a", negative_current_output_offs_a_o, 10'h005);
    chk("pos_a", positive_current_output_offs_a_o, 10'h000);
    chk("pos_b", positive_current_output_offs_b_o, 10'h3ff);
    chk("neg_b", negative_current_output_offs_b_o, 10'h000);
    tx_sleep_i = 1'b1;
    strobe(1);
    chk("out_current", tx_out_current_on_o, 10'h000);
    chk("stage2", interp_stage2_en_o, 10'h001);
    tx_sleep_i = 1'b0;
    strobe(1);
    chk("out_current", tx_out_current_on_o, 10'h001);
    mult_en_i = 1'b1;
    strobe(8);
    chk("mult_src", sync_clk_src_mult_o, 10'h001);
    chk("ref_sample", tx_ref_sample_o, tx_reference_clock_in_i);
    @(negedge clk_i);
    chk("ref_sample", tx_ref_sample_o, tx_reference_clock_in_i);
    $display("transmit tests done");
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    chk("gain", shared_gain_o, 10'h0ff);
    chk("coarse_b", coarse_b_o, 10'h000);
    chk("fine_a", fine_a_o, 10'h000);
    chk("neg_a", negative_current_output_offs_a_o, 10'h000);
    $display("reset test done");
    wrap_up();
  end
endmodule // tb_top
